// ### bench/asip_host_model.sv
// host side of the two interrupt wires, with board pull-ups
`default_nettype none
module asip_host_model (
	// pin drivers of the device
	input wire logic a_o_i,
	input wire logic a_oe_i,
	input wire logic b_o_i,
	input wire logic b_oe_i,
	// levels seen by the host
	output logic a_wire_o,
	output logic b_wire_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released line floats to the pull-up, never to the last driven level
	assign a_wire_o = a_oe_i ? a_o_i : 1'b1;
	assign b_wire_o = b_oe_i ? b_o_i : 1'b1;
endmodule : asip_host_model
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for acquisition step and interrupt pin control
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1;
	logic [31:0] kept;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] ev = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic act = 1'b0;
	logic vld = 1'b0;
	logic [asip_pkg::P_W-1:0] p = '0;
	logic [asip_pkg::T_W-1:0] t = '0;
	logic [7:0] pu = 8'h12;
	logic [7:0] pl = 8'h34;
	logic [7:0] tt = 8'h56;
	logic [7:0] rdata;
	logic [7:0] cfg = 8'h00;
	logic [7:0] en = 8'h00;
	logic [7:0] rt = 8'h00;
	logic [7:0] mk[4] = '{8'h3F, 8'h33, 8'hFF, 8'hFF};
	logic [asip_pkg::P_W-1:0] cp;
	logic [asip_pkg::T_W-1:0] ct;
	logic start, a_o, a_oe, b_o, b_oe, a_w, b_w;
	logic rd_due = 1'b0;
	logic pin_due = 1'b0;
	logic tgt_due = 1'b0;
	logic [7:0] q_rd[$];
	logic [5:0] q_pin[$];
	logic [31:0] q_tgt[$];
	int q_per[$];
	int n_errors = 0;
	int samples_checked = 0;
	int seed = 32'h7bfd;
	int cnt = 0;

	always #5 clk_i = ~clk_i;

	asip_top #(.CYC_PER_SEC(4)) asip_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rd_i(rd), .reg_rdata_o(rdata),
		.active_mode_select_i(act), .out_valid_i(vld),
		.out_p_i(p), .out_t_i(t), .meas_start_o(start),
		.pressure_target_upper_i(pu), .pressure_target_lower_i(pl),
		.temperature_target_i(tt),
		.cmp_p_target_o(cp), .cmp_t_target_o(ct),
		.src_event_i(ev),
		.interrupt_pin_a_o(a_o), .interrupt_pin_a_oe_o(a_oe),
		.interrupt_pin_b_o(b_o), .interrupt_pin_b_oe_o(b_oe)
	);

	asip_host_model asip_host_model_i (
		.a_o_i(a_o), .a_oe_i(a_oe), .b_o_i(b_o), .b_oe_i(b_oe),
		.a_wire_o(a_w), .b_wire_o(b_w)
	);

	task automatic test_done();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic report(string nm, logic [31:0] e, logic [31:0] s);
		samples_checked++;
		if (e !== s) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : report

	task automatic cmp_rd(logic [7:0] e);
		report("reg_rdata_o", 32'(e), 32'(rdata));
	endtask : cmp_rd

	task automatic cmp_pin(logic [5:0] e);
		report("pins", 32'(e), 32'({a_o, a_oe, a_w, b_o, b_oe, b_w}));
	endtask : cmp_pin

	task automatic cmp_tgt(logic [31:0] e);
		report("targets", e, {cp, ct});
	endtask : cmp_tgt

	task automatic cmp_per(int e, int s);
		report("step period", 32'(e), 32'(s));
	endtask : cmp_per

	// expected {out, oe, wire} of one pin
	function automatic logic [2:0] pexp(logic pol, logic kind, logic on);
		logic lv;
		lv = on ? pol : ~pol;
		return kind ? {pol, on, on ? pol : 1'b1} : {lv, 1'b1, lv};
	endfunction : pexp

	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(negedge clk_i);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
	endtask : wr_reg

	task automatic rd_reg(logic [7:0] a, logic [7:0] e);
		@(negedge clk_i);
		addr = a;
		rd = 1'b1;
		rd_due = 1'b1;
		q_rd.push_back(e);
		@(negedge clk_i);
		rd = 1'b0;
		rd_due = 1'b0;
	endtask : rd_reg

	task automatic ev_chk(logic [7:0] e);
		@(negedge clk_i);
		ev = e;
		q_pin.push_back({pexp(cfg[5], cfg[4], |(e & en & rt)),
			pexp(cfg[1], cfg[0], |(e & en & ~rt))});
		pin_due = 1'b1;
		@(negedge clk_i);
		pin_due = 1'b0;
	endtask : ev_chk

	task automatic tgt_chk(logic [31:0] e);
		@(negedge clk_i);
		q_tgt.push_back(e);
		tgt_due = 1'b1;
		@(negedge clk_i);
		tgt_due = 1'b0;
	endtask : tgt_chk

	task automatic cap();
		@(negedge clk_i);
		p = asip_pkg::P_W'($random(seed));
		t = asip_pkg::T_W'($random(seed));
		vld = 1'b1;
		@(negedge clk_i);
		vld = 1'b0;
	endtask : cap

	// bounded wait for one step pulse, then step past it
	task automatic wait_start();
		for (int k = 0; k < 200 && start !== 1'b1; k++) @(negedge clk_i);
		if (start !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED meas_start_o expected pulse seen none");
			test_done();
		end
		@(negedge clk_i);
	endtask : wait_start

	// results are settled one step after the edge that makes them
	always @(posedge clk_i) begin
		#1;
		cnt = cnt + 1;
		if (rd_due) cmp_rd(q_rd.pop_front());
		if (pin_due) cmp_pin(q_pin.pop_front());
		if (tgt_due) cmp_tgt(q_tgt.pop_front());
		if (start === 1'b1) begin
			if (q_per.size() > 0) cmp_per(q_per.pop_front(), cnt);
			cnt = 0;
		end
	end

	initial begin
		repeat (4) @(negedge clk_i);
		rst_i = 1'b0;
		for (int i = 0; i < 5; i++) rd_reg(8'h27 + 8'(i), 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h27 + 8'(i), 8'hFF);
			rd_reg(8'h27 + 8'(i), mk[i]);
		end
		wr_reg(8'h2B, 8'hFF);
		rd_reg(8'h2B, 8'h00);
		wr_reg(8'h27, 8'h00);
		for (int i = 0; i < 16; i++) begin
			cfg = {2'b00, 2'(i >> 2), 2'b00, 2'(i)};
			en = 8'($random(seed));
			rt = 8'($random(seed));
			wr_reg(8'h28, cfg);
			wr_reg(8'h29, en);
			wr_reg(8'h2A, rt);
			repeat (4) ev_chk(8'($random(seed)));
			ev_chk(8'hFF);
		end
		wr_reg(8'h27, 8'h30);
		cap();
		tgt_chk({p, t});
		kept = {p, t};
		cap();
		tgt_chk(kept);
		wr_reg(8'h27, 8'h10);
		wr_reg(8'h27, 8'h30);
		cap();
		tgt_chk({p, t});
		wr_reg(8'h27, 8'h20);
		tgt_chk({4'h0, pu, pl, 4'h0, tt});
		for (int x = 0; x < 3; x++) begin
			wr_reg(8'h27, 8'(x));
			act = 1'b1;
			wait_start();
			q_per.push_back(4 << x);
			wait_start();
			act = 1'b0;
		end
		// clock enable low: write and read are both refused
		rd_reg(8'h27, 8'h02);
		ce = 1'b0;
		wr_reg(8'h27, 8'h0F);
		rd_reg(8'h29, 8'h02);
		ce = 1'b1;
		rd_reg(8'h27, 8'h02);
		// reset in mid-run returns every register and pin to idle
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		cfg = 8'h00;
		en = 8'h00;
		rt = 8'h00;
		ev_chk(8'hFF);
		rd_reg(8'h29, 8'h00);
		repeat (3) @(negedge clk_i);
		test_done();
	end
endmodule : tb
`default_nettype wire

// ### hdl/asip_pkg.sv
// constants for acquisition step and interrupt pin control
`default_nettype none
package asip_pkg;
	// register offsets on the serial register port
	localparam logic [7:0] OFF_ACQ_CTRL = 8'h27;
	localparam logic [7:0] OFF_PIN_CFG = 8'h28;
	localparam logic [7:0] OFF_SRC_EN = 8'h29;
	localparam logic [7:0] OFF_ROUTE = 8'h2A;
	// reset values
	localparam logic [7:0] RST_ACQ_CTRL = 8'h00;
	localparam logic [7:0] RST_PIN_CFG = 8'h00;
	localparam logic [7:0] RST_SRC_EN = 8'h00;
	localparam logic [7:0] RST_ROUTE = 8'h00;
	// writable bit masks, reserved bits stay zero
	localparam logic [7:0] MASK_ACQ_CTRL = 8'h3F;
	localparam logic [7:0] MASK_PIN_CFG = 8'h33;
	localparam logic [7:0] MASK_FULL = 8'hFF;
	// acquisition control fields
	localparam int BIT_CAPTURE_OUTPUT = 5;
	localparam int BIT_ALARM_SEL = 4;
	localparam int EXP_MSB = 3;
	localparam int EXP_LSB = 0;
	// pin configuration fields
	localparam int BIT_PIN_A_POL = 5;
	localparam int BIT_PIN_A_KIND = 4;
	localparam int BIT_PIN_B_POL = 1;
	localparam int BIT_PIN_B_KIND = 0;
	// source order in enable and routing registers
	localparam int SRC_DATA_READY = 7;
	localparam int SRC_FIFO = 6;
	localparam int SRC_P_WINDOW = 5;
	localparam int SRC_T_WINDOW = 4;
	localparam int SRC_P_THRESH = 3;
	localparam int SRC_T_THRESH = 2;
	localparam int SRC_P_CHANGE = 1;
	localparam int SRC_T_CHANGE = 0;
	// widths
	localparam int P_W = 20;
	localparam int T_W = 12;
	// timing: one step unit is one second
	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_UNIT_NS = 1_000_000_000;
	localparam int CYC_PER_STEP_UNIT = STEP_UNIT_NS / CLK_PERIOD_NS;
	localparam int CYC_W = 27;
	localparam int SEC_W = 16;
	// capture sequencer, one-hot
	typedef enum logic [2:0] {
		CAP_IDLE = 3'b001,
		CAP_ARMED = 3'b010,
		CAP_DONE = 3'b100
	} asip_cap_state_t;
endpackage : asip_pkg
`default_nettype wire

// ### hdl/asip_step_timer.sv
// autonomous acquisition step timer, 2^exponent seconds
`default_nettype none
module asip_step_timer #(
	parameter int CYC_PER_SEC = asip_pkg::CYC_PER_STEP_UNIT
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// control
	input wire logic run_i,
	input wire logic [3:0] exp_i,
	// measurement request pulse
	output logic tick_o
);
	logic [asip_pkg::CYC_W-1:0] cyc_ff;
	logic [asip_pkg::SEC_W-1:0] sec_ff;
	logic tick_ff;
	logic [asip_pkg::SEC_W-1:0] step_secs;
	logic sec_end;
	logic step_end;

	// 2^exp seconds, 1 up to 32768
	assign step_secs = asip_pkg::SEC_W'(1) << exp_i;
	assign sec_end = cyc_ff == asip_pkg::CYC_W'(CYC_PER_SEC - 1);
	// a shortened step mid-count ends at the next second boundary instead of wrapping 16 bits
	assign step_end = sec_end && (sec_ff >= step_secs - 1'b1);
	assign tick_o = tick_ff;

	// standby restarts the count so a new step starts from zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc_ff <= '0;
			sec_ff <= '0;
			tick_ff <= 1'b0;
		end else if (ce_i) begin
			tick_ff <= run_i && step_end;
			if (!run_i || sec_end) begin
				cyc_ff <= '0;
			end else begin
				cyc_ff <= cyc_ff + 1'b1;
			end
			if (!run_i || step_end) begin
				sec_ff <= '0;
			end else if (sec_end) begin
				sec_ff <= sec_ff + 1'b1;
			end
		end
	end

	// step change mid-count: sec may pass the new end, guard the count
	a_sec_in_range: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && run_i && !sec_end |=> sec_ff <= $past(sec_ff) + 1'b1)
		else $error("step second counter jumped");
endmodule : asip_step_timer
`default_nettype wire

// ### hdl/asip_top.sv
// acquisition step, alarm target select and interrupt pin control
`default_nettype none
module asip_top #(
	parameter int CYC_PER_SEC = asip_pkg::CYC_PER_STEP_UNIT
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// register port from the serial interface
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// measurement path
	input wire logic active_mode_select_i,
	input wire logic out_valid_i,
	input wire logic [asip_pkg::P_W-1:0] out_p_i,
	input wire logic [asip_pkg::T_W-1:0] out_t_i,
	output logic meas_start_o,
	// programmed targets
	input wire logic [7:0] pressure_target_upper_i,
	input wire logic [7:0] pressure_target_lower_i,
	input wire logic [7:0] temperature_target_i,
	// targets for window and threshold comparisons
	output logic [asip_pkg::P_W-1:0] cmp_p_target_o,
	output logic [asip_pkg::T_W-1:0] cmp_t_target_o,
	// event flags of the functional blocks
	input wire logic [7:0] src_event_i,
	// interrupt pins
	output logic interrupt_pin_a_o,
	output logic interrupt_pin_a_oe_o,
	output logic interrupt_pin_b_o,
	output logic interrupt_pin_b_oe_o
);
	// registers
	logic [7:0] acq_ctrl_ff;
	logic [7:0] pin_cfg_ff;
	logic [7:0] src_en_ff;
	logic [7:0] route_ff;
	logic [7:0] rdata_ff;
	logic [asip_pkg::P_W-1:0] cap_p_ff;
	logic [asip_pkg::T_W-1:0] cap_t_ff;
	asip_pkg::asip_cap_state_t cap_state_ff;
	asip_pkg::asip_cap_state_t nxt_cap_state;
	logic pin_a_ff;
	logic pin_a_oe_ff;
	logic pin_b_ff;
	logic pin_b_oe_ff;

	// register decode
	function automatic logic wr_hit(input logic [7:0] addr,
		input logic [7:0] off);
		wr_hit = addr == off;
	endfunction : wr_hit

	function automatic logic [7:0] masked(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask);
		masked = (new_v & mask) | (old_v & ~mask);
	endfunction : masked

	logic wr_acq;
	logic wr_pin;
	logic wr_en;
	logic wr_route;
	logic [7:0] rd_mux;
	assign wr_acq = reg_wr_i && wr_hit(reg_addr_i, asip_pkg::OFF_ACQ_CTRL);
	assign wr_pin = reg_wr_i && wr_hit(reg_addr_i, asip_pkg::OFF_PIN_CFG);
	assign wr_en = reg_wr_i && wr_hit(reg_addr_i, asip_pkg::OFF_SRC_EN);
	assign wr_route = reg_wr_i && wr_hit(reg_addr_i, asip_pkg::OFF_ROUTE);
	assign rd_mux = wr_hit(reg_addr_i, asip_pkg::OFF_ACQ_CTRL) ? acq_ctrl_ff
		: wr_hit(reg_addr_i, asip_pkg::OFF_PIN_CFG) ? pin_cfg_ff
		: wr_hit(reg_addr_i, asip_pkg::OFF_SRC_EN) ? src_en_ff
		: wr_hit(reg_addr_i, asip_pkg::OFF_ROUTE) ? route_ff
		: 8'h00;
	assign reg_rdata_o = rdata_ff;

	// named fields
	logic capture_output;
	logic alarm_sel;
	logic [3:0] acquisition_interval_exponent;
	logic pin_a_polarity;
	logic pin_a_drive_kind;
	logic pin_b_polarity;
	logic pin_b_drive_kind;
	assign capture_output = acq_ctrl_ff[asip_pkg::BIT_CAPTURE_OUTPUT];
	assign alarm_sel = acq_ctrl_ff[asip_pkg::BIT_ALARM_SEL];
	assign acquisition_interval_exponent =
		acq_ctrl_ff[asip_pkg::EXP_MSB:asip_pkg::EXP_LSB];
	assign pin_a_polarity = pin_cfg_ff[asip_pkg::BIT_PIN_A_POL];
	assign pin_a_drive_kind = pin_cfg_ff[asip_pkg::BIT_PIN_A_KIND];
	assign pin_b_polarity = pin_cfg_ff[asip_pkg::BIT_PIN_B_POL];
	assign pin_b_drive_kind = pin_cfg_ff[asip_pkg::BIT_PIN_B_KIND];

	// register file; reserved bits are masked so they never store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acq_ctrl_ff <= asip_pkg::RST_ACQ_CTRL;
			pin_cfg_ff <= asip_pkg::RST_PIN_CFG;
			src_en_ff <= asip_pkg::RST_SRC_EN;
			route_ff <= asip_pkg::RST_ROUTE;
			rdata_ff <= 8'h00;
		end else if (ce_i) begin
			if (wr_acq) begin
				acq_ctrl_ff <= masked(acq_ctrl_ff, reg_wdata_i,
					asip_pkg::MASK_ACQ_CTRL);
			end
			if (wr_pin) begin
				pin_cfg_ff <= masked(pin_cfg_ff, reg_wdata_i,
					asip_pkg::MASK_PIN_CFG);
			end
			if (wr_en) begin
				src_en_ff <= masked(src_en_ff, reg_wdata_i,
					asip_pkg::MASK_FULL);
			end
			if (wr_route) begin
				route_ff <= masked(route_ff, reg_wdata_i,
					asip_pkg::MASK_FULL);
			end
			if (reg_rd_i) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	// capture sequencer: done state waits for the bit to drop
	always_comb begin
		nxt_cap_state = cap_state_ff;
		case (cap_state_ff)
			asip_pkg::CAP_IDLE: begin
				if (capture_output) begin
					nxt_cap_state = asip_pkg::CAP_ARMED;
				end
			end
			asip_pkg::CAP_ARMED: begin
				if (!capture_output) begin
					nxt_cap_state = asip_pkg::CAP_IDLE;
				end else if (out_valid_i) begin
					nxt_cap_state = asip_pkg::CAP_DONE;
				end
			end
			asip_pkg::CAP_DONE: begin
				if (!capture_output) begin
					nxt_cap_state = asip_pkg::CAP_IDLE;
				end
			end
			default: begin
				nxt_cap_state = asip_pkg::CAP_IDLE;
			end
		endcase
	end

	logic cap_take;
	assign cap_take = cap_state_ff == asip_pkg::CAP_ARMED &&
		capture_output && out_valid_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_state_ff <= asip_pkg::CAP_IDLE;
			cap_p_ff <= '0;
			cap_t_ff <= '0;
		end else if (ce_i) begin
			cap_state_ff <= nxt_cap_state;
			if (cap_take) begin
				cap_p_ff <= out_p_i;
				cap_t_ff <= out_t_i;
			end
		end
	end

	// targets; captured values are meaningless until the host captures
	logic [asip_pkg::P_W-1:0] prog_p_target;
	logic [asip_pkg::T_W-1:0] prog_t_target;
	assign prog_p_target = asip_pkg::P_W'({pressure_target_upper_i,
		pressure_target_lower_i});
	assign prog_t_target = asip_pkg::T_W'(temperature_target_i);
	assign cmp_p_target_o = alarm_sel ? cap_p_ff : prog_p_target;
	assign cmp_t_target_o = alarm_sel ? cap_t_ff : prog_t_target;

	// periodic acquisition in active mode
	asip_step_timer #(
		.CYC_PER_SEC(CYC_PER_SEC)
	) u_step (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.run_i(active_mode_select_i),
		.exp_i(acquisition_interval_exponent),
		.tick_o(meas_start_o)
	);

	// gate, route and combine
	logic [7:0] req_live;
	logic [7:0] req_a;
	logic [7:0] req_b;
	logic any_a;
	logic any_b;
	assign req_live = src_event_i & src_en_ff;
	assign req_a = req_live & route_ff;
	assign req_b = req_live & ~route_ff;
	assign any_a = |req_a;
	assign any_b = |req_b;

	// open-drain drives only the asserted level, idle is released
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_a_ff <= 1'b1;
			pin_a_oe_ff <= 1'b1;
			pin_b_ff <= 1'b1;
			pin_b_oe_ff <= 1'b1;
		end else if (ce_i) begin
			pin_a_ff <= pin_a_drive_kind ? pin_a_polarity
				: (any_a ~^ pin_a_polarity);
			pin_a_oe_ff <= pin_a_drive_kind ? any_a : 1'b1;
			pin_b_ff <= pin_b_drive_kind ? pin_b_polarity
				: (any_b ~^ pin_b_polarity);
			pin_b_oe_ff <= pin_b_drive_kind ? any_b : 1'b1;
		end
	end
	assign interrupt_pin_a_o = pin_a_ff;
	assign interrupt_pin_a_oe_o = pin_a_oe_ff;
	assign interrupt_pin_b_o = pin_b_ff;
	assign interrupt_pin_b_oe_o = pin_b_oe_ff;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_armed_sample;
		ce_i && cap_state_ff == asip_pkg::CAP_ARMED && capture_output &&
			out_valid_i;
	endsequence

	sequence s_done_sample;
		ce_i && cap_state_ff == asip_pkg::CAP_DONE && out_valid_i;
	endsequence

	a_resv_read_zero: assert property (
		acq_ctrl_ff[7:6] == 2'b00 && pin_cfg_ff[7:6] == 2'b00 &&
		pin_cfg_ff[3:2] == 2'b00)
		else $error("reserved bit stored");
	a_capture_next: assert property (
		s_armed_sample |=> cap_p_ff == $past(out_p_i) &&
		cap_t_ff == $past(out_t_i) && cap_state_ff == asip_pkg::CAP_DONE)
		else $error("output not captured");
	a_no_recapture: assert property (
		s_done_sample ##0 capture_output |=> $stable(cap_p_ff) &&
		$stable(cap_t_ff))
		else $error("recapture without clear and set");
	a_prog_target: assert property (
		!alarm_sel |-> cmp_p_target_o[15:0] ==
		{pressure_target_upper_i, pressure_target_lower_i})
		else $error("programmed target not selected");
	a_capt_target: assert property (
		alarm_sel |-> cmp_p_target_o == cap_p_ff && cmp_t_target_o == cap_t_ff)
		else $error("captured target not selected");
	a_pin_a_level: assert property (
		ce_i && !pin_a_drive_kind |=> interrupt_pin_a_oe_o &&
		interrupt_pin_a_o == ($past(any_a) ? $past(pin_a_polarity)
		: !$past(pin_a_polarity)))
		else $error("pin a level wrong");
	a_pin_b_release: assert property (
		ce_i && pin_b_drive_kind && !any_b |=> !interrupt_pin_b_oe_o)
		else $error("open-drain pin b not released");
	a_disabled_silent: assert property (
		ce_i && src_en_ff == 8'h00 && !pin_a_drive_kind && !pin_a_polarity
		|=> interrupt_pin_a_o)
		else $error("disabled source asserted pin a");
	a_route_exclusive: assert property (
		(req_a & req_b) == 8'h00 && (req_a | req_b) == req_live)
		else $error("source not on exactly one pin");
	a_ce_freeze: assert property (
		!ce_i |=> $stable(acq_ctrl_ff) && $stable(interrupt_pin_b_o))
		else $error("state moved with clock enable low");
endmodule : asip_top
`default_nettype wire
